// file: include/tmr8_pkg.sv
// package of register map, field layout and mode codes for the 8-bit timer
package tmr8_pkg;
	// ==============================
	// register addresses (8-bit I/O space)
	localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'h15;
	localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h6E;
	localparam logic [7:0] ADDR_CONTROL_A   = 8'h24;
	localparam logic [7:0] ADDR_CONTROL_B   = 8'h25;
	localparam logic [7:0] ADDR_COUNT       = 8'h26;
	localparam logic [7:0] ADDR_COMPARE_A   = 8'h27;
	localparam logic [7:0] ADDR_COMPARE_B   = 8'h28;
	// ==============================
	// field positions
	localparam int FORCE_A_BIT   = 7;
	localparam int FORCE_B_BIT   = 6;
	localparam int WAVE_MSB_BIT  = 3;
	localparam int CS_LSB        = 0;
	localparam int ACT_A_LSB     = 6;
	localparam int ACT_B_LSB     = 4;
	localparam int WAVE_LOW_LSB  = 0;
	localparam int MATCH_B_BIT   = 2;
	localparam int MATCH_A_BIT   = 1;
	localparam int OVF_BIT       = 0;
	// ==============================
	// reset values and constants
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [7:0] COUNT_MAX   = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [2:0] IRQ_MASK    = 3'h7;
	// ==============================
	// clock source codes
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	// ==============================
	// output action codes
	localparam logic [1:0] ACT_OFF    = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;
	// ==============================
	// waveform modes
	localparam logic [2:0] WM_NORMAL     = 3'h0;
	localparam logic [2:0] WM_PHASE_FF   = 3'h1;
	localparam logic [2:0] WM_CLEAR_MATCH = 3'h2;
	localparam logic [2:0] WM_FAST_FF    = 3'h3;
	localparam logic [2:0] WM_PHASE_CMP  = 3'h5;
	localparam logic [2:0] WM_FAST_CMP   = 3'h7;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cpu_req_t;

	typedef struct packed {
		logic [1:0] action;
		logic       match;
		logic       force_hit;
	} chan_ctl_t;
endpackage : tmr8_pkg

// file: rtl/tmr8_prescaler.sv
// prescaler and clock-source selector producing a one-cycle count tick
`timescale 1ns/10ps
module tmr8_prescaler
	import tmr8_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clk_en_i,
	input  wire logic [2:0] sel_i,
	input  wire logic       ext_pin_i,
	output logic            tick_o
);
	// ==============================
	// prescale counter
	logic [9:0] div_ff;
	logic       ext_ff;
	logic       ext_rise;
	logic       ext_fall;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_ff <= 10'h000;
			ext_ff <= 1'b0;
		end else if (clk_en_i) begin
			div_ff <= div_ff + 10'h001;
			// pin sampled regardless of port direction so software may drive it
			ext_ff <= ext_pin_i;
		end
	end

	assign ext_rise = ext_pin_i & ~ext_ff;
	assign ext_fall = ~ext_pin_i & ext_ff;

	// ==============================
	// source selection
	always_comb begin
		case (sel_i)
			CS_STOP:     tick_o = 1'b0;
			CS_DIV1:     tick_o = clk_en_i;
			CS_DIV8:     tick_o = clk_en_i & (div_ff[2:0] == 3'h7);
			CS_DIV64:    tick_o = clk_en_i & (div_ff[5:0] == 6'h3F);
			CS_DIV256:   tick_o = clk_en_i & (div_ff[7:0] == 8'hFF);
			CS_DIV1024:  tick_o = clk_en_i & (div_ff == 10'h3FF);
			CS_EXT_FALL: tick_o = clk_en_i & ext_fall;
			CS_EXT_RISE: tick_o = clk_en_i & ext_rise;
			default:     tick_o = 1'b0;
		endcase
	end

	a_stop_no_tick: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sel_i == CS_STOP) |-> !tick_o)
		else $error("tick while stopped");
endmodule : tmr8_prescaler

// file: rtl/tmr8_timer.sv
// 8-bit timer with two compare channels and its register file
// Operation
// - writing one to force A in non-PWM mode forces a match on output A
// - writing one to force B in non-PWM mode forces a match on output B
// - forced match acts per the current action bits; strobe not stored
// - forced match sets no flag and never clears the counter
// - force bits always read zero
// - reserved control B bits 5:4 and mask/flag bits 7:3 read zero
// - control B bit 3 is the top waveform mode bit with control A low bits
// - control B bits 2:0 select the counter clock source
// - external pin edges count even when the pin is an output
// - counter readable and writable as the live count
// - counter write blocks compare match on the next timer tick
// - compare A continuously compared; match flags or drives output A
// - compare B continuously compared; match flags or drives output B
// - enables in bits 2..0; request needs enable, global bit and flag
// - match with compare B sets flag bit 2
// - match with compare A sets flag bit 1
// - overflow sets flag bit 0, point depends on mode
// - flag cleared by vector acknowledge or by writing one
// - overflow at max in normal/clear/fast-ff, bottom phase, top fast-cmp
// - non-PWM actions: off, toggle, clear, set
`timescale 1ns/10ps
module tmr8_timer
	import tmr8_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clk_en_i,
	input  wire cpu_req_t   cpu_i,
	output logic [7:0]      rdata_o,
	input  wire logic       global_irq_en_i,
	input  wire logic [2:0] irq_ack_i,
	output logic [2:0]      irq_req_o,
	input  wire logic       ext_count_pin_i,
	output logic            wave_out_a_o,
	output logic            wave_out_b_o
);
	// ==============================
	// register state
	logic [7:0] ctrl_a_ff;
	logic [3:0] ctrl_b_ff;
	logic [7:0] count_ff;
	logic [7:0] cmp_a_ff;
	logic [7:0] cmp_b_ff;
	logic [2:0] irq_en_ff;
	logic [2:0] flags_ff;
	logic       block_ff;
	logic       down_ff;
	logic [7:0] rdata_ff;

	logic [7:0] nxt_count;
	logic       nxt_down;
	logic [2:0] nxt_flags;
	logic [7:0] nxt_rdata;

	// ==============================
	// decode
	wire wr_flags = cpu_i.wr && (cpu_i.addr == ADDR_IRQ_FLAGS);
	wire wr_en    = cpu_i.wr && (cpu_i.addr == ADDR_IRQ_ENABLES);
	wire wr_ca    = cpu_i.wr && (cpu_i.addr == ADDR_CONTROL_A);
	wire wr_cb    = cpu_i.wr && (cpu_i.addr == ADDR_CONTROL_B);
	wire wr_cnt   = cpu_i.wr && (cpu_i.addr == ADDR_COUNT);
	wire wr_oa    = cpu_i.wr && (cpu_i.addr == ADDR_COMPARE_A);
	wire wr_ob    = cpu_i.wr && (cpu_i.addr == ADDR_COMPARE_B);

	wire [2:0] wave_mode = {ctrl_b_ff[WAVE_MSB_BIT], ctrl_a_ff[WAVE_LOW_LSB +: 2]};
	wire       mode_pwm  = wave_mode[0];
	wire       mode_phase = (wave_mode == WM_PHASE_FF) || (wave_mode == WM_PHASE_CMP);
	wire       top_cmp   = (wave_mode == WM_CLEAR_MATCH) || (wave_mode == WM_PHASE_CMP) ||
	                       (wave_mode == WM_FAST_CMP);
	wire [7:0] top_val   = top_cmp ? cmp_a_ff : COUNT_MAX;

	// strobes act only on the write cycle and are never stored
	wire force_a = wr_cb && cpu_i.wdata[FORCE_A_BIT] && !mode_pwm;
	wire force_b = wr_cb && cpu_i.wdata[FORCE_B_BIT] && !mode_pwm;

	// ==============================
	// clock source
	logic tick;

	tmr8_prescaler u_presc (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clk_en_i  (clk_en_i),
		.sel_i     (ctrl_b_ff[CS_LSB +: 3]),
		.ext_pin_i (ext_count_pin_i),
		.tick_o    (tick)
	);

	// ==============================
	// compare and overflow events
	wire match_a = tick && !block_ff && (count_ff == cmp_a_ff);
	wire match_b = tick && !block_ff && (count_ff == cmp_b_ff);
	wire at_top  = (count_ff == top_val);

	logic ovf_evt;
	always_comb begin
		ovf_evt = 1'b0;
		if (tick) begin
			case (wave_mode)
				WM_PHASE_FF, WM_PHASE_CMP: ovf_evt = (count_ff == COUNT_BOTTOM) && down_ff;
				WM_FAST_CMP:               ovf_evt = at_top;
				default:                   ovf_evt = (count_ff == COUNT_MAX);
			endcase
		end
	end

	// ==============================
	// counter sequence; forced matches never reach here
	always_comb begin
		nxt_count = count_ff;
		nxt_down  = down_ff;
		if (wr_cnt) begin
			nxt_count = cpu_i.wdata;
		end else if (tick) begin
			if (mode_phase) begin
				if (!down_ff && at_top) begin
					nxt_down  = 1'b1;
					nxt_count = count_ff - 8'h01;
				end else if (down_ff && count_ff == COUNT_BOTTOM) begin
					nxt_down  = 1'b0;
					nxt_count = count_ff + 8'h01;
				end else begin
					nxt_count = down_ff ? count_ff - 8'h01 : count_ff + 8'h01;
				end
			end else if (top_cmp && at_top) begin
				nxt_count = COUNT_BOTTOM;
			end else begin
				nxt_count = count_ff + 8'h01;
			end
		end
	end

	// ==============================
	// flags: hardware set wins over any clear in the same cycle
	wire [2:0] set_flags = {match_b, match_a, ovf_evt};
	wire [2:0] clr_flags = irq_ack_i | (wr_flags ? cpu_i.wdata[2:0] : 3'h0);
	assign nxt_flags = set_flags | (flags_ff & ~clr_flags);

	// ==============================
	// read mux
	always_comb begin
		case (cpu_i.addr)
			ADDR_IRQ_FLAGS:   nxt_rdata = {5'h00, flags_ff};
			ADDR_IRQ_ENABLES: nxt_rdata = {5'h00, irq_en_ff};
			ADDR_CONTROL_A:   nxt_rdata = {ctrl_a_ff[7:4], 2'h0, ctrl_a_ff[1:0]};
			ADDR_CONTROL_B:   nxt_rdata = {4'h0, ctrl_b_ff};
			ADDR_COUNT:       nxt_rdata = count_ff;
			ADDR_COMPARE_A:   nxt_rdata = cmp_a_ff;
			ADDR_COMPARE_B:   nxt_rdata = cmp_b_ff;
			default:          nxt_rdata = 8'h00;
		endcase
	end

	// ==============================
	// state update
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_a_ff <= RESET_VALUE;
			ctrl_b_ff <= 4'h0;
			cmp_a_ff  <= RESET_VALUE;
			cmp_b_ff  <= RESET_VALUE;
			irq_en_ff <= 3'h0;
			rdata_ff  <= RESET_VALUE;
		end else if (clk_en_i) begin
			if (wr_ca) ctrl_a_ff <= cpu_i.wdata;
			if (wr_cb) ctrl_b_ff <= cpu_i.wdata[3:0];
			if (wr_oa) cmp_a_ff <= cpu_i.wdata;
			if (wr_ob) cmp_b_ff <= cpu_i.wdata;
			if (wr_en) irq_en_ff <= cpu_i.wdata[2:0];
			if (cpu_i.rd) rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_ff <= RESET_VALUE;
			down_ff  <= 1'b0;
			flags_ff <= 3'h0;
			block_ff <= 1'b0;
		end else if (clk_en_i) begin
			count_ff <= nxt_count;
			down_ff  <= nxt_down;
			flags_ff <= nxt_flags;
			// block held until the next timer tick consumes it
			block_ff <= wr_cnt | (block_ff & ~tick);
		end
	end

	assign rdata_o   = rdata_ff;
	assign irq_req_o = global_irq_en_i ? (flags_ff & irq_en_ff) : 3'h0;

	// ==============================
	// waveform channels
	wire pwm_lvl_a = mode_phase ? (count_ff < cmp_a_ff) ^ ctrl_a_ff[ACT_A_LSB] :
	                              (count_ff <= cmp_a_ff) ^ ctrl_a_ff[ACT_A_LSB];
	wire pwm_lvl_b = mode_phase ? (count_ff < cmp_b_ff) ^ ctrl_a_ff[ACT_B_LSB] :
	                              (count_ff <= cmp_b_ff) ^ ctrl_a_ff[ACT_B_LSB];
	chan_ctl_t ctl_a;
	chan_ctl_t ctl_b;
	assign ctl_a = '{action: ctrl_a_ff[ACT_A_LSB +: 2], match: match_a, force_hit: force_a};
	assign ctl_b = '{action: ctrl_a_ff[ACT_B_LSB +: 2], match: match_b, force_hit: force_b};

	tmr8_wave_out u_wave_a (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.clk_en_i    (clk_en_i),
		.ctl_i       (ctl_a),
		.pwm_i       (mode_pwm && ctrl_a_ff[ACT_A_LSB + 1]),
		.pwm_level_i (pwm_lvl_a),
		.wave_o      (wave_out_a_o)
	);

	tmr8_wave_out u_wave_b (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.clk_en_i    (clk_en_i),
		.ctl_i       (ctl_b),
		.pwm_i       (mode_pwm && ctrl_a_ff[ACT_B_LSB + 1]),
		.pwm_level_i (pwm_lvl_b),
		.wave_o      (wave_out_b_o)
	);

	// ==============================
	// checks
	a_force_no_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && force_a && !match_a && !tick) |=> !(flags_ff[MATCH_A_BIT] && !$past(flags_ff[MATCH_A_BIT])))
		else $error("forced match set a flag");
	a_force_no_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && (force_a || force_b) && !tick && !wr_cnt) |=> (count_ff == $past(count_ff)))
		else $error("forced match moved counter");
	a_cb_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && cpu_i.rd && cpu_i.addr == ADDR_CONTROL_B) |=> (rdata_o[7:4] == 4'h0))
		else $error("force or reserved bits read nonzero");
	a_flag_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && cpu_i.rd && (cpu_i.addr == ADDR_IRQ_FLAGS || cpu_i.addr == ADDR_IRQ_ENABLES))
		|=> (rdata_o[7:3] == 5'h00))
		else $error("reserved mask or flag bits nonzero");
	a_cnt_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && wr_cnt) |=> (count_ff == $past(cpu_i.wdata)))
		else $error("counter write lost");
	a_block: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && wr_cnt) |=> (!match_a && !match_b) until_with tick)
		else $error("match not blocked after write");
	a_match_b: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && match_b) |=> flags_ff[MATCH_B_BIT])
		else $error("match b flag missed");
	a_match_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && match_a) |=> flags_ff[MATCH_A_BIT])
		else $error("match a flag missed");
	a_ovf_normal: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && tick && wave_mode == WM_NORMAL && count_ff == COUNT_MAX) |=> flags_ff[OVF_BIT])
		else $error("overflow flag missed");
	a_w1c: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && wr_flags && cpu_i.wdata[OVF_BIT] && !ovf_evt) |=> !flags_ff[OVF_BIT])
		else $error("write one did not clear");
	a_irq: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		irq_req_o[OVF_BIT] == (global_irq_en_i && flags_ff[OVF_BIT] && irq_en_ff[OVF_BIT]))
		else $error("overflow request mismatch");
	a_w0_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && wr_flags && !cpu_i.wdata[MATCH_A_BIT] && !irq_ack_i[MATCH_A_BIT] && flags_ff[MATCH_A_BIT])
		|=> flags_ff[MATCH_A_BIT])
		else $error("zero write cleared flag");
endmodule : tmr8_timer

// file: rtl/tmr8_wave_out.sv
// one waveform output channel
`timescale 1ns/10ps
module tmr8_wave_out
	import tmr8_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clk_en_i,
	input  wire chan_ctl_t  ctl_i,
	input  wire logic       pwm_i,
	input  wire logic       pwm_level_i,
	output logic            wave_o
);
	logic nxt_wave;
	logic wave_ff;

	// forced match uses the action bits live at the strobe
	always_comb begin
		nxt_wave = wave_ff;
		if (pwm_i) begin
			nxt_wave = pwm_level_i;
		end else if (ctl_i.match | ctl_i.force_hit) begin
			case (ctl_i.action)
				ACT_TOGGLE: nxt_wave = ~wave_ff;
				ACT_CLEAR:  nxt_wave = 1'b0;
				ACT_SET:    nxt_wave = 1'b1;
				default:    nxt_wave = wave_ff;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wave_ff <= 1'b0;
		end else if (clk_en_i) begin
			wave_ff <= nxt_wave;
		end
	end

	assign wave_o = wave_ff;

	a_force_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && !pwm_i && ctl_i.force_hit && ctl_i.action == ACT_SET) |=> wave_ff)
		else $error("forced set missed");
	a_force_tog: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && !pwm_i && ctl_i.force_hit && ctl_i.action == ACT_TOGGLE) |=> (wave_ff != $past(wave_ff)))
		else $error("forced toggle missed");
endmodule : tmr8_wave_out

// file: tb/tmr8_timer_tb_top.sv
// self-checking bench for the 8-bit timer register file and compare channels
`timescale 1ns/10ps
module tmr8_timer_tb_top import tmr8_pkg::*;;
	// ==============================
	// signals and design under test
	logic       ref_clk_i;
	logic       rst_i;
	logic       clk_en_i;
	cpu_req_t   cpu_i;
	logic [7:0] rdata_o;
	logic       global_irq_en_i;
	logic [2:0] irq_ack_i;
	logic [2:0] irq_req_o;
	logic       ext_count_pin_i;
	logic       wave_out_a_o;
	logic       wave_out_b_o;
	int         num_errors;
	int         compares;
	int         cycles;

	tmr8_timer dut (
		.ref_clk_i       (ref_clk_i),
		.rst_i           (rst_i),
		.clk_en_i        (clk_en_i),
		.cpu_i           (cpu_i),
		.rdata_o         (rdata_o),
		.global_irq_en_i (global_irq_en_i),
		.irq_ack_i       (irq_ack_i),
		.irq_req_o       (irq_req_o),
		.ext_count_pin_i (ext_count_pin_i),
		.wave_out_a_o    (wave_out_a_o),
		.wave_out_b_o    (wave_out_b_o)
	);

	always #2 ref_clk_i = ~ref_clk_i;

	// ==============================
	// bus and compare helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge ref_clk_i);
		cpu_i <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge ref_clk_i);
		cpu_i <= '0;
	endtask : wr_reg

	// read data is registered at the edge that takes the request
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge ref_clk_i);
		cpu_i <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge ref_clk_i);
		cpu_i <= '0;
		#1;
		chk(rdata_o, exp);
	endtask : rd_chk

	// slow pulses so the synchroniser never misses an edge
	task automatic pin_pulses(input int n);
		repeat (n) begin
			@(posedge ref_clk_i);
			ext_count_pin_i <= 1'b1;
			repeat (4) @(posedge ref_clk_i);
			ext_count_pin_i <= 1'b0;
			repeat (4) @(posedge ref_clk_i);
		end
	endtask : pin_pulses

	// ==============================
	// scenarios
	task automatic t_reset;
		rd_chk(ADDR_IRQ_FLAGS, 8'h00);
		rd_chk(ADDR_IRQ_ENABLES, 8'h00);
		rd_chk(ADDR_CONTROL_B, 8'h00);
		rd_chk(8'h00, 8'h00);
	endtask : t_reset

	task automatic t_reserved;
		wr_reg(ADDR_IRQ_ENABLES, 8'hFF);
		rd_chk(ADDR_IRQ_ENABLES, 8'h07);
		wr_reg(ADDR_IRQ_ENABLES, 8'h00);
		// normal mode, action off: force has nothing to do here
		wr_reg(ADDR_CONTROL_B, 8'hF0);
		rd_chk(ADDR_CONTROL_B, 8'h00);
		wr_reg(ADDR_CONTROL_B, 8'h08);
		rd_chk(ADDR_CONTROL_B, 8'h08);
		wr_reg(ADDR_CONTROL_B, 8'h00);
		wr_reg(ADDR_IRQ_FLAGS, 8'hFF);
		rd_chk(ADDR_IRQ_FLAGS, 8'h00);
	endtask : t_reserved

	task automatic t_count_rw;
		wr_reg(ADDR_COUNT, 8'h5A);
		rd_chk(ADDR_COUNT, 8'h5A);
		repeat (20) @(posedge ref_clk_i);
		rd_chk(ADDR_COUNT, 8'h5A);
		@(posedge ref_clk_i);
		clk_en_i <= 1'b0;
		wr_reg(ADDR_COUNT, 8'h11);
		clk_en_i <= 1'b1;
		rd_chk(ADDR_COUNT, 8'h5A);
	endtask : t_count_rw

	task automatic t_force;
		logic [1:0] acts [4];
		logic       exp  [4];
		acts = '{ACT_SET, ACT_TOGGLE, ACT_TOGGLE, ACT_CLEAR};
		exp  = '{1'b1, 1'b0, 1'b1, 1'b0};
		wr_reg(ADDR_COMPARE_A, 8'h80);
		wr_reg(ADDR_COMPARE_B, 8'h90);
		wr_reg(ADDR_COUNT, 8'h10);
		for (int i = 0; i < 4; i++) begin
			wr_reg(ADDR_CONTROL_A, {acts[i], acts[i], 4'h0});
			wr_reg(ADDR_CONTROL_B, 8'hC0);
			repeat (3) @(posedge ref_clk_i);
			#1;
			chk({6'h00, wave_out_a_o, wave_out_b_o}, {6'h00, exp[i], exp[i]});
		end
		rd_chk(ADDR_COUNT, 8'h10);
		rd_chk(ADDR_IRQ_FLAGS, 8'h00);
		wr_reg(ADDR_CONTROL_A, 8'h00);
	endtask : t_force

	task automatic t_ext_count;
		wr_reg(ADDR_COMPARE_A, 8'h40);
		wr_reg(ADDR_COMPARE_B, 8'h81);
		wr_reg(ADDR_CONTROL_B, {5'h00, CS_EXT_RISE});
		wr_reg(ADDR_COUNT, 8'h3E);
		pin_pulses(3);
		rd_chk(ADDR_COUNT, 8'h41);
		rd_chk(ADDR_IRQ_FLAGS, 8'h02);
		wr_reg(ADDR_IRQ_FLAGS, 8'h02);
		// write lands on the compare value: next tick must not match
		wr_reg(ADDR_COUNT, 8'h40);
		pin_pulses(1);
		rd_chk(ADDR_COUNT, 8'h41);
		rd_chk(ADDR_IRQ_FLAGS, 8'h00);
		wr_reg(ADDR_CONTROL_B, {5'h00, CS_EXT_FALL});
		wr_reg(ADDR_COUNT, 8'h80);
		pin_pulses(2);
		rd_chk(ADDR_COUNT, 8'h82);
		rd_chk(ADDR_IRQ_FLAGS, 8'h04);
		wr_reg(ADDR_IRQ_FLAGS, 8'h07);
		wr_reg(ADDR_COUNT, 8'hFE);
		pin_pulses(2);
		rd_chk(ADDR_IRQ_FLAGS, 8'h01);
		wr_reg(ADDR_CONTROL_B, 8'h00);
		wr_reg(ADDR_IRQ_FLAGS, 8'h07);
	endtask : t_ext_count

	task automatic t_irq;
		wr_reg(ADDR_COMPARE_A, 8'h20);
		wr_reg(ADDR_COMPARE_B, 8'h30);
		wr_reg(ADDR_IRQ_ENABLES, 8'h07);
		global_irq_en_i <= 1'b1;
		wr_reg(ADDR_COUNT, 8'h00);
		wr_reg(ADDR_CONTROL_B, {5'h00, CS_DIV1});
		repeat (300) @(posedge ref_clk_i);
		wr_reg(ADDR_CONTROL_B, 8'h00);
		rd_chk(ADDR_IRQ_FLAGS, 8'h07);
		chk({5'h00, irq_req_o}, 8'h07);
		@(posedge ref_clk_i);
		global_irq_en_i <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		chk({5'h00, irq_req_o}, 8'h00);
		global_irq_en_i <= 1'b1;
		wr_reg(ADDR_IRQ_ENABLES, 8'h02);
		#1;
		chk({5'h00, irq_req_o}, 8'h02);
		wr_reg(ADDR_IRQ_ENABLES, 8'h07);
		wr_reg(ADDR_IRQ_FLAGS, 8'h00);
		rd_chk(ADDR_IRQ_FLAGS, 8'h07);
		wr_reg(ADDR_IRQ_FLAGS, 8'h02);
		rd_chk(ADDR_IRQ_FLAGS, 8'h05);
		@(posedge ref_clk_i);
		irq_ack_i <= 3'h4;
		@(posedge ref_clk_i);
		irq_ack_i <= 3'h0;
		rd_chk(ADDR_IRQ_FLAGS, 8'h01);
		chk({5'h00, irq_req_o}, 8'h01);
		wr_reg(ADDR_IRQ_FLAGS, 8'h01);
		rd_chk(ADDR_IRQ_FLAGS, 8'h00);
	endtask : t_irq

	// clear-on-match wraps at compare A, overflow stays clear below max
	task automatic t_ctc;
		wr_reg(ADDR_CONTROL_A, 8'h02);
		wr_reg(ADDR_COMPARE_A, 8'h05);
		wr_reg(ADDR_COUNT, 8'h00);
		wr_reg(ADDR_CONTROL_B, {5'h00, CS_EXT_RISE});
		pin_pulses(7);
		rd_chk(ADDR_COUNT, 8'h01);
		rd_chk(ADDR_IRQ_FLAGS, 8'h02);
		// fast PWM: strobes stay zero on every control B write
		wr_reg(ADDR_CONTROL_A, 8'h03);
		wr_reg(ADDR_CONTROL_B, {5'h00, CS_STOP});
		rd_chk(ADDR_COUNT, 8'h01);
		wr_reg(ADDR_CONTROL_A, 8'h00);
		wr_reg(ADDR_IRQ_FLAGS, 8'h07);
	endtask : t_ctc

	// ==============================
	// verdict and hang guard
	task automatic summarize;
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end

	initial begin
		ref_clk_i       = 1'b0;
		rst_i           = 1'b1;
		clk_en_i        = 1'b1;
		cpu_i           = '0;
		global_irq_en_i = 1'b0;
		irq_ack_i       = 3'h0;
		ext_count_pin_i = 1'b0;
		num_errors      = 0;
		compares        = 0;
		cycles          = 0;
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_reserved();
		t_count_rw();
		t_force();
		t_ext_count();
		t_irq();
		t_ctc();
		summarize();
	end
endmodule : tmr8_timer_tb_top
